// >>> hdl/scdm_static_dram_mux.sv
// scdm_static_dram_mux: static memory cycle engine with burst support and the
// internal dram row/column address multiplexer with its indicator pin.
// assumes: one bus clock; transfer_ack_n and rd_data come from pins; the dram
// sequencer (outside) supplies the dram cycle and column phase qualifiers.
`timescale 1ns/1ns
`default_nettype none

module scdm_static_dram_mux
  import scdm_pkg::*;
(
  input  wire logic                clk,                    // bus clock
  input  wire logic                sys_rst,                // async reset, high
  input  wire logic                req_valid,              // start a static access
  input  wire logic                req_write,              // 1 write, 0 read
  input  wire logic [SCDM_AW-1:0]  req_addr,               // logical start address
  input  wire logic [SCDM_DW-1:0]  req_wdata,              // write data, all beats
  input  wire logic [SCDM_BEW-1:0] req_be_n,               // byte lanes, low active
  input  wire logic [SCDM_BLW-1:0] req_beats,              // extra burst beats
  input  wire logic                cfg_async,              // asynchronous static mode
  input  wire logic [SCDM_WCW-1:0] cfg_wait,               // first-beat wait states
  input  wire logic [SCDM_WCW-1:0] cfg_burst_wait,         // later-beat wait states
  input  wire logic [1:0]          cfg_port_size,          // 8/16/32-bit port
  input  wire logic                external_mux_select,    // disable internal mux
  input  wire logic                mux_indicator_force,    // drive indicator anyway
  input  wire logic                per_select_mux_disable, // current select unmuxed
  input  wire logic                mux_mapping_select,     // mode 0 / mode 1
  input  wire logic                dram_cycle,             // dram owns the address
  input  wire logic                dram_col_phase,         // page/edo column phase
  input  wire logic                sdram_cmd_phase,        // sdram rd/wr/load mode
  input  wire logic                transfer_ack_n,         // ack pin, low active
  input  wire logic [SCDM_DW-1:0]  rd_data,                // data pins in
  output logic                     req_ready,              // idle, takes a request
  output logic                     req_done,               // access finished pulse
  output logic [SCDM_DW-1:0]       rdata,                  // captured read data
  output logic                     rdata_valid,            // read beat pulse
  output logic                     cs_n,                   // chip select, low
  output logic                     oe_n,                   // output enable, low
  output logic                     we_n,                   // write enable, low
  output logic [SCDM_BEW-1:0]      byte_enable_n,          // byte enables, low
  output logic [SCDM_AW-1:0]       addr_pins,              // address pins
  output logic [SCDM_DW-1:0]       wr_data,                // data pins out
  output logic                     wr_data_oe,             // data pins driven
  output logic                     mux_indicator_pin,      // mux indicator out
  output logic                     mux_indicator_oe        // indicator driven
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // address increment per beat
  function automatic logic [SCDM_AW-1:0] scdm_step(input logic [1:0] ps);
    logic [SCDM_AW-1:0] s;
    s = 28'h0000001;
    if (ps == SCDM_PS_16) begin
      s = 28'h0000002;
    end else if (ps == SCDM_PS_32) begin
      s = 28'h0000004;
    end
    return s;
  endfunction

  // internal row/column multiplexer on A13:A0, upper pins stay plain
  function automatic logic [SCDM_AW-1:0] scdm_mux(input logic [SCDM_AW-1:0] a, input logic [1:0] ps,
                                                  input logic md, input logic col);
    logic [SCDM_AW-1:0] o;
    o = a;
    o[SCDM_MUX_HI:0] = 14'h0000;
    if (md == SCDM_MAP_MODE0) begin
      case (ps)
        SCDM_PS_8: begin
          o[11]  = col ? a[19] : a[18];
          o[8:0] = col ? a[8:0] : {a[17:13], a[11], a[12], a[10], a[9]};
        end
        SCDM_PS_16: begin
          o[12]  = col ? a[20] : a[19];
          o[9:1] = col ? a[9:1] : a[18:10];
        end
        default: begin
          o[13]   = col ? a[21] : a[20];
          o[10:2] = col ? a[10:2] : a[19:11];
        end
      endcase
    end else begin
      case (ps)
        SCDM_PS_8: begin
          o[13:0] = col ? {3'h0, a[10], a[20], a[19], a[7:0]} : a[21:8];
        end
        SCDM_PS_16: begin
          o[13:1] = col ? {3'h0, a[10:1]} : a[21:9];
        end
        default: begin
          o[13:2] = col ? {3'h0, a[10:2]} : a[21:10];
        end
      endcase
    end
    return o;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    scdm_state_t          st;
    logic                 ack_s1;
    logic                 ack_s2;
    logic                 ack_s3;
    logic                 ack_armed;
    logic                 async;
    logic                 write;
    logic [1:0]           ps;
    logic [SCDM_BLW-1:0]  beats;
    logic [SCDM_WCW-1:0]  wait_cnt;
    logic                 strobe_on;
    logic                 cs_n;
    logic [SCDM_BEW-1:0]  be_n;
    logic [SCDM_BEW-1:0]  be_rise_n;
    logic [SCDM_AW-1:0]   laddr;
    logic [SCDM_AW-1:0]   pins;
    logic [SCDM_DW-1:0]   wdata;
    logic                 wdata_oe;
    logic [SCDM_DW-1:0]   rdata;
    logic                 rdata_valid;
    logic                 done;
    logic                 ready;
    logic                 ind;
    logic                 ind_oe;
  } scdm_regs_t;

  scdm_regs_t q;
  scdm_regs_t d;
  logic       ack_low;
  logic       ack_high;
  logic       beat_done;
  logic       oe_n_q;
  logic       we_n_q;
  logic [3:0] be_fall_n_q;

  // ack filter: a level counts once the second and third stage agree
  assign ack_low  = ~q.ack_s2 & ~q.ack_s3;
  assign ack_high = q.ack_s2 & q.ack_s3;
  // beat ends on the edge where ack is seen low after the wait states
  assign beat_done = (q.st == SCDM_ACTIVE) && (q.wait_cnt == 6'h00) && q.ack_armed && ack_low;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic use_internal;
    use_internal = 1'b0;
    d = q;
    d.ack_s1      = transfer_ack_n;
    d.ack_s2      = q.ack_s1;
    d.ack_s3      = q.ack_s2;
    d.done        = 1'b0;
    d.rdata_valid = 1'b0;
    if (ack_high) begin
      d.ack_armed = 1'b1;
    end
    case (q.st)
      SCDM_IDLE: begin
        d.ready = 1'b1;
        if (req_valid && q.ready) begin
          d.ready    = 1'b0;
          d.async    = cfg_async;
          d.write    = req_write;
          d.ps       = cfg_port_size;
          d.beats    = req_beats;
          d.laddr    = req_addr;
          d.be_n     = req_be_n;
          d.wdata    = req_wdata;
          d.wdata_oe = req_write;
          d.strobe_on = 1'b1;
          if (cfg_async) begin
            d.wait_cnt = (cfg_wait < SCDM_ASYNC_MIN_WAIT) ? SCDM_ASYNC_MIN_WAIT : cfg_wait;
            d.cs_n     = 1'b0;
            d.st       = SCDM_ACTIVE;
          end else begin
            d.wait_cnt = cfg_wait;
            d.st       = SCDM_SETUP;                           // strobe leads select
          end
        end
      end
      SCDM_SETUP: begin
        d.cs_n      = 1'b0;
        d.be_rise_n = q.be_n;
        d.st        = SCDM_ACTIVE;
      end
      SCDM_ACTIVE: begin
        if (q.wait_cnt != 6'h00) begin
          d.wait_cnt = q.wait_cnt - 6'h01;
        end else if (beat_done) begin
          d.ack_armed = 1'b0;
          if (!q.write) begin
            d.rdata       = rd_data;
            d.rdata_valid = 1'b1;
          end
          if (q.beats != 4'h0) begin
            d.beats    = q.beats - 4'h1;
            d.laddr    = q.laddr + scdm_step(q.ps);
            if (q.async) begin
              d.wait_cnt  = (cfg_burst_wait < SCDM_ASYNC_MIN_WAIT) ? SCDM_ASYNC_MIN_WAIT : cfg_burst_wait;
              d.strobe_on = 1'b0;
              d.st        = SCDM_HOLD;
            end else begin
              d.wait_cnt = cfg_burst_wait;                     // sync burst keeps strobes low
            end
          end else if (q.async) begin
            d.strobe_on = 1'b0;
            d.st        = SCDM_HOLD;
          end else begin
            d.cs_n      = 1'b1;
            d.be_rise_n = SCDM_BE_IDLE;
            d.strobe_on = 1'b0;
            d.wdata_oe  = 1'b0;
            d.done      = 1'b1;
            d.st        = SCDM_IDLE;
          end
        end
      end
      SCDM_HOLD: begin
        // async only: select stays low while the strobe rises; a reloaded wait count means a beat follows
        if (q.wait_cnt != 6'h00) begin
          d.strobe_on = 1'b1;
          d.st        = SCDM_ACTIVE;
        end else begin
          d.cs_n     = 1'b1;
          d.wdata_oe = 1'b0;
          d.done     = 1'b1;
          d.st       = SCDM_IDLE;
        end
      end
      default: begin
        d.st       = SCDM_IDLE;
        d.cs_n     = 1'b1;
        d.strobe_on = 1'b0;
      end
    endcase
    // address pins: internal mux only when neither disable applies
    use_internal = dram_cycle && !external_mux_select && !per_select_mux_disable;
    if (use_internal) begin
      d.pins = scdm_mux(q.laddr, q.ps, mux_mapping_select, dram_col_phase | sdram_cmd_phase);
    end else begin
      d.pins = q.laddr;
    end
    d.ind_oe = external_mux_select | mux_indicator_force | (per_select_mux_disable & dram_cycle);
    d.ind    = d.ind_oe & dram_cycle & (dram_col_phase | sdram_cmd_phase);
  end

  ////////////////////////////////////////////////////////////////////////////
  // rising edge registers

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{st: SCDM_IDLE, ack_s1: 1'b1, ack_s2: 1'b1, ack_s3: 1'b1, ack_armed: 1'b0, async: 1'b0,
             write: 1'b0, ps: SCDM_PS_8, beats: 4'h0, wait_cnt: 6'h00, strobe_on: 1'b0, cs_n: 1'b1,
             be_n: SCDM_BE_IDLE, be_rise_n: SCDM_BE_IDLE, laddr: SCDM_ADDR_RST, pins: SCDM_ADDR_RST,
             wdata: SCDM_DATA_RST, wdata_oe: 1'b0, rdata: SCDM_DATA_RST, rdata_valid: 1'b0,
             done: 1'b0, ready: 1'b0, ind: 1'b0, ind_oe: 1'b0};
    end else begin
      q <= d;
    end
  end

  // falling edge strobes follow the rising-edge strobe request
  always_ff @(negedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      oe_n_q      <= 1'b1;
      we_n_q      <= 1'b1;
      be_fall_n_q <= SCDM_BE_IDLE;
    end else begin
      oe_n_q      <= ~(q.strobe_on & ~q.write);
      we_n_q      <= ~(q.strobe_on & q.write);
      be_fall_n_q <= q.strobe_on ? q.be_n : SCDM_BE_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign req_ready         = q.ready;
  assign req_done          = q.done;
  assign rdata             = q.rdata;
  assign rdata_valid       = q.rdata_valid;
  assign cs_n              = q.cs_n;
  assign oe_n              = oe_n_q;
  assign we_n              = we_n_q;
  assign byte_enable_n     = q.async ? be_fall_n_q : q.be_rise_n; // lane timing per mode
  assign addr_pins         = q.pins;
  assign wr_data           = q.wdata;
  assign wr_data_oe        = q.wdata_oe;
  assign mux_indicator_pin = q.ind;
  assign mux_indicator_oe  = q.ind_oe;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking scdm_cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence scdm_strobe_low;
    !oe_n_q || !we_n_q;
  endsequence

  sequence scdm_strobe_high;
    oe_n_q && we_n_q;
  endsequence

  chk_sync_strobe_lead: assert property (!q.async && $fell(q.cs_n) |-> !($past(oe_n_q) && $past(we_n_q)))
    else $error("sync strobe not active before select");
  chk_sync_strobe_trail: assert property (!q.async && $rose(q.cs_n) |->
                                          oe_n_q && we_n_q && !($past(oe_n_q) && $past(we_n_q)))
    else $error("sync strobe trailing edge wrong");
  chk_async_nest: assert property (q.async && (!oe_n_q || !we_n_q) |-> !q.cs_n)
    else $error("async strobe outside select");
  chk_async_min_wait: assert property (q.async && $fell(q.cs_n) |-> !beat_done)
    else $error("async beat ended without wait state");
  chk_async_strobe_fall: assert property (q.async && $fell(q.cs_n) |=> scdm_strobe_low)
    else $error("async strobe late after select");
  chk_async_strobe_rise: assert property (q.async && beat_done |=> scdm_strobe_high)
    else $error("async strobe not released after ack");
  chk_end_on_ack: assert property (!q.async && beat_done && q.beats == 4'h0 |=> q.cs_n && q.done)
    else $error("sync cycle did not end on ack");
  chk_read_capture: assert property (beat_done && !q.write |=> q.rdata_valid && q.rdata == $past(rd_data))
    else $error("read data not captured at ack");
  chk_mode1_col_zero: assert property (dram_cycle && !external_mux_select && !per_select_mux_disable &&
                                       mux_mapping_select && (dram_col_phase || sdram_cmd_phase)
                                       |=> q.pins[13:11] == 3'h0)
    else $error("mode 1 column upper pins not zero");
  chk_indicator_low: assert property (!dram_col_phase && !sdram_cmd_phase |=> !q.ind)
    else $error("indicator high outside column phase");
  chk_plain_address: assert property (external_mux_select |=> q.pins == $past(q.laddr))
    else $error("address multiplexed while external mux selected");

endmodule

`default_nettype wire

// >>> hdl/scdm_pkg.sv
// scdm_pkg: constants and types for the static cycle engine and dram address mux
// assumes a single 250 MHz bus clock domain and 28-bit external address pins
package scdm_pkg;

  // bus widths
  localparam int unsigned SCDM_AW   = 28;
  localparam int unsigned SCDM_DW   = 32;
  localparam int unsigned SCDM_BEW  = 4;
  localparam int unsigned SCDM_WCW  = 6;  // wait-state counter width
  localparam int unsigned SCDM_BLW  = 4;  // burst beat counter width

  // port width codes
  localparam logic [1:0] SCDM_PS_8  = 2'h0;
  localparam logic [1:0] SCDM_PS_16 = 2'h1;
  localparam logic [1:0] SCDM_PS_32 = 2'h2;

  // mapping select codes
  localparam logic SCDM_MAP_MODE0 = 1'b0;
  localparam logic SCDM_MAP_MODE1 = 1'b1;

  // least wait states of an asynchronous static cycle
  localparam logic [5:0] SCDM_ASYNC_MIN_WAIT = 6'h01;

  // reset values
  localparam logic [3:0]  SCDM_BE_IDLE   = 4'hf;
  localparam logic [27:0] SCDM_ADDR_RST  = 28'h0000000;
  localparam logic [31:0] SCDM_DATA_RST  = 32'h00000000;

  // multiplexed pin window
  localparam int unsigned SCDM_MUX_HI = 13;

  // cycle states, one-hot
  typedef enum logic [3:0] {
    SCDM_IDLE   = 4'b0001,
    SCDM_SETUP  = 4'b0010,
    SCDM_ACTIVE = 4'b0100,
    SCDM_HOLD   = 4'b1000
  } scdm_state_t;

endpackage

// >>> tb/scdm_mem_model.sv
// scdm_mem_model: behavioural static memory standing on the pins of the cycle engine
// assumes one bus clock; acks come in repeating windows while the chip select is low
`timescale 1ns/1ns
`default_nettype none

module scdm_mem_model
  import scdm_pkg::*;
(
  input  wire logic               clk,            // bus clock
  input  wire logic               cs_n,           // chip select, low
  input  wire logic               we_n,           // write enable, low
  input  wire logic [SCDM_AW-1:0] addr_pins,      // address pins
  input  wire logic [SCDM_DW-1:0] wr_data,        // data from the engine
  input  wire logic [3:0]         ack_dly,        // cycles before the first ack window
  output logic                    transfer_ack_n, // ack pin, low
  output logic [SCDM_DW-1:0]      rd_data,        // data towards the engine
  output logic [SCDM_DW-1:0]      wr_last,        // last word written
  output int                      wr_cnt          // ack windows that carried a write
);
  int   cnt;
  logic wr_seen = 1'b0;

  initial transfer_ack_n = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // six cycles low, six high, so the ack is seen low long enough and high between beats
  always @(posedge clk) begin
    cnt <= cs_n ? 0 : cnt + 1;
    transfer_ack_n <= !(!cs_n && cnt >= ack_dly && ((cnt - ack_dly) % 12) < 6);
  end

  // data is valid only while ack is low, otherwise the inverse shows
  assign rd_data = transfer_ack_n ? ~{addr_pins, 4'ha} : {addr_pins, 4'ha};

  // one write counted per ack window in which the write strobe was low
  always @(posedge clk) begin
    if (!transfer_ack_n && !we_n) begin
      wr_seen <= 1'b1;
      wr_last <= wr_data;
    end
    if (transfer_ack_n && wr_seen) begin
      wr_seen <= 1'b0;
      wr_cnt <= wr_cnt + 1;
    end
  end
endmodule

`default_nettype wire

// >>> tb/scdm_static_dram_mux_test.sv
// scdm_static_dram_mux_test: directed bench for the static cycle engine and the address mux
// assumes the memory model on the pins and a 250 MHz bus clock; control bits are plain ports
`timescale 1ns/1ns
`default_nettype none

module scdm_static_dram_mux_test
  import scdm_pkg::*;
;
  localparam logic [SCDM_AW-1:0] MUX_ADDR = 28'h9e3b5a7;

  logic                clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, cfg_async = 1'b0;
  logic                external_mux_select = 1'b0, mux_indicator_force = 1'b0, per_select_mux_disable = 1'b0;
  logic                mux_mapping_select = 1'b0, dram_cycle = 1'b0, dram_col_phase = 1'b0, sdram_cmd_phase = 1'b0;
  logic [SCDM_AW-1:0]  req_addr = 28'h0000000;
  logic [SCDM_DW-1:0]  req_wdata = 32'hc3a596f0;
  logic [SCDM_BEW-1:0] req_be_n = 4'h9;
  logic [SCDM_BLW-1:0] req_beats = 4'h0;
  logic [3:0]          ack_dly = 4'h0;
  logic [SCDM_WCW-1:0] cfg_wait = 6'h00, cfg_burst_wait = 6'h00;
  logic [1:0]          cfg_port_size = 2'h2;
  logic                transfer_ack_n, req_ready, req_done, rdata_valid, cs_n, oe_n, we_n, wr_data_oe;
  logic                mux_indicator_pin, mux_indicator_oe;
  logic [SCDM_DW-1:0]  rd_data, rdata, wr_data, wr_last;
  logic [SCDM_BEW-1:0] byte_enable_n;
  logic [SCDM_AW-1:0]  addr_pins;
  int                  wr_cnt, err_count, n_checks, cycles;

  scdm_static_dram_mux dut (.clk, .sys_rst, .req_valid, .req_write, .req_addr, .req_wdata, .req_be_n,
    .req_beats, .cfg_async, .cfg_wait, .cfg_burst_wait, .cfg_port_size, .external_mux_select,
    .mux_indicator_force, .per_select_mux_disable, .mux_mapping_select, .dram_cycle, .dram_col_phase,
    .sdram_cmd_phase, .transfer_ack_n, .rd_data, .req_ready, .req_done, .rdata, .rdata_valid, .cs_n,
    .oe_n, .we_n, .byte_enable_n, .addr_pins, .wr_data, .wr_data_oe, .mux_indicator_pin, .mux_indicator_oe);

  scdm_mem_model mem (.clk, .cs_n, .we_n, .addr_pins, .wr_data, .ack_dly, .transfer_ack_n, .rd_data,
    .wr_last, .wr_cnt);

  ////////////////////////////////////////////////////////////////////////////////
  // clock and cycle ceiling
  initial forever #2 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare, report and close
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // expected multiplexed pins A13..A0; pins above stay plain, unused pins read 0
  function automatic logic [SCDM_AW-1:0] exp_mux(logic [SCDM_AW-1:0] a, logic m, logic [1:0] s, logic c);
    logic [SCDM_AW-1:0] r;
    int                 b;
    r = a;
    for (int p = 0; p < 14; p++) begin
      b = -1;
      if (p >= s && m) b = c ? (p > 10 ? -1 : p) : p + 8;
      else if (p >= s && p <= 8 + s) b = c ? p : p + 9;
      else if (p >= s && p == 11 + s) b = c ? 19 + s : 18 + s;
      if (m && c && s == 0 && (p == 8 || p == 9)) b = p + 11;
      if (!m && !c && s == 0 && (p == 2 || p == 3)) b = 14 - p;
      r[p] = (b < 0) ? 1'b0 : a[b];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // edge and nesting watch on the strobes and the select
  always @(oe_n or we_n) if (!sys_rst) check("strobe edge", clk, 1'b0);
  always @(cs_n) if (!sys_rst) check("select edge", clk, 1'b1);
  always @(byte_enable_n) if (!sys_rst) check("lane edge", clk, !cfg_async);
  always @(negedge cs_n) if (!sys_rst) check("strobe at select", oe_n & we_n, cfg_async);
  always @(posedge cs_n) if (!sys_rst) check("strobe at deselect", oe_n & we_n, cfg_async);
  always @(clk) if (cfg_async && cs_n === 1'b1) check("inside select", {oe_n, we_n, byte_enable_n}, 6'h3f);

  ////////////////////////////////////////////////////////////////////////////////
  // request held until the edge where ready is seen high
  task automatic start(input logic w, input logic [SCDM_AW-1:0] a, input logic [3:0] nb);
    int k;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_beats <= nb;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (req_ready !== 1'b1 && k < 50);
    check("request taken", req_ready, 1'b1);
    req_valid <= 1'b0;
  endtask

  // follow the access to its done pulse, checking every read beat
  task automatic finish(output int nv, output int cyc);
    nv = 0;
    cyc = 0;
    do begin
      @(posedge clk);
      cyc++;
      if (cyc == 1) check("data drive", wr_data_oe, req_write);
      if (cyc == 2) check("lanes active", byte_enable_n, req_be_n);
      if (rdata_valid === 1'b1) begin
        check("read beat", rdata, {28'(req_addr + (nv << cfg_port_size)), 4'ha});
        nv++;
      end
    end while (req_done !== 1'b1 && cyc < 400);
    check("access ended", req_done, 1'b1);
    check("data drive off", wr_data_oe, 1'b0);
    check("select at end", cs_n, 1'b1);
  endtask

  task automatic run(input logic w, input logic as, input logic [5:0] wt, input logic [3:0] nb);
    int nv, cyc, w0;
    cfg_async <= as;
    cfg_wait <= wt;
    cfg_burst_wait <= wt;
    w0 = wr_cnt;
    start(w, 28'h0123450, nb);
    finish(nv, cyc);
    repeat (3) @(posedge clk);
    if (w) check("write beats", wr_cnt - w0, nb + 1);
    if (w) check("write word", wr_last, req_wdata);
    if (!w) check("read beats", nv, nb + 1);
    check("wait honoured", cyc > wt, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic               m, c;
    logic [1:0]         s;
    logic [2:0]         ovr;
    logic [SCDM_AW-1:0] ea;
    int                 nv, cyc;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    // sync and async, read and write, bursts with prompt acks, singles with wait states
    for (int i = 0; i < 8; i++) begin
      cfg_port_size <= 2'(i % 3);
      ack_dly <= 4'(2 * i);
      run(i[0], i[1], i[2] ? 6'h08 : 6'h00, i[2] ? 4'h0 : 4'h3);
    end
    // every mapping, width and phase, then external, forced and per-select overrides
    cfg_async <= 1'b0;
    ack_dly <= 4'hf;
    for (int i = 0; i < 15; i++) begin
      m = (i < 12) ? i[0] : 1'b1;
      c = (i < 12) ? i[1] : i[0];
      s = (i < 12) ? 2'(i / 4) : SCDM_PS_32;
      ovr = (i < 12) ? 3'h0 : 3'(4 >> (i - 12));
      ea = (ovr[2] | ovr[0]) ? MUX_ADDR : exp_mux(MUX_ADDR, m, s, c);
      mux_mapping_select <= m;
      cfg_port_size <= s;
      dram_cycle <= 1'b1;
      dram_col_phase <= c & !m;
      sdram_cmd_phase <= c & m;
      {external_mux_select, mux_indicator_force, per_select_mux_disable} <= ovr;
      start(1'b0, MUX_ADDR, 4'h0);
      repeat (3) @(posedge clk);
      check("mux address", addr_pins, ea);
      check("indicator drive", mux_indicator_oe, |ovr);
      check("indicator level", mux_indicator_pin, (|ovr) & c);
      dram_cycle <= 1'b0;
      finish(nv, cyc);
      repeat (3) @(posedge clk);
    end
    wrap_up();
  end
endmodule

`default_nettype wire
